/* File: bench/qsas_assertions.sv */
`timescale 1ns/10ps
module qsas_assertions (
	// Clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// Control pins
	input wire logic CONVERSION_START_N,
	input wire logic CLOCK_SOURCE_SELECT,
	input wire logic CHIP_SELECT_N,
	input wire logic READ_STROBE_N,
	// Status outputs
	input wire logic DATA_BUS_OE,
	input wire logic BUSY,
	input wire logic END_OF_CONVERSION_N,
	input wire logic TRACK_HOLD,
	// Read channel
	input wire logic ARREADY,
	input wire logic RVALID
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!NRST);
	property p_oe;
		DATA_BUS_OE == (!CHIP_SELECT_N && !READ_STROBE_N);
	endproperty
	a_oe: assert property (p_oe)
		else $error("bus enable mismatch");
	property p_busy_rise;
		$rose(CONVERSION_START_N) && !$past(BUSY) |-> BUSY;
	endproperty
	a_busy_rise: assert property (p_busy_rise)
		else $error("busy missed start");
	property p_hold_rise;
		$rose(CONVERSION_START_N) && !$past(BUSY) |=> TRACK_HOLD;
	endproperty
	a_hold_rise: assert property (p_hold_rise)
		else $error("hold missed start");
	property p_conv_time;
		$rose(TRACK_HOLD) && !CLOCK_SOURCE_SELECT |-> ##41 $fell(END_OF_CONVERSION_N);
	endproperty
	a_conv_time: assert property (p_conv_time)
		else $error("first conversion time wrong");
	property p_conv_gap;
		$rose(END_OF_CONVERSION_N) && !CLOCK_SOURCE_SELECT |->
			(##1 !BUSY) or (##41 $fell(END_OF_CONVERSION_N));
	endproperty
	a_conv_gap: assert property (p_conv_gap)
		else $error("next conversion time wrong");
	property p_eoc_width;
		$fell(END_OF_CONVERSION_N) |=> !END_OF_CONVERSION_N ##1 END_OF_CONVERSION_N;
	endproperty
	a_eoc_width: assert property (p_eoc_width)
		else $error("end pulse width wrong");
	property p_busy_end;
		$fell(BUSY) |-> !TRACK_HOLD;
	endproperty
	a_busy_end: assert property (p_busy_end)
		else $error("hold kept after busy");
	property p_hold_in_busy;
		TRACK_HOLD |-> BUSY;
	endproperty
	a_hold_in_busy: assert property (p_hold_in_busy)
		else $error("hold outside busy");
	property p_last_eoc;
		$fell(BUSY) |-> !$past(END_OF_CONVERSION_N, 2);
	endproperty
	a_last_eoc: assert property (p_last_eoc)
		else $error("busy fell before last pulse");
	property p_r_block;
		RVALID |-> !ARREADY;
	endproperty
	a_r_block: assert property (p_r_block)
		else $error("read address taken while answering");
endmodule : qsas_assertions
bind qsas_top qsas_assertions u_chk (.CLK(CLK), .NRST(NRST),
	.CONVERSION_START_N(CONVERSION_START_N), .CLOCK_SOURCE_SELECT(CLOCK_SOURCE_SELECT),
	.CHIP_SELECT_N(CHIP_SELECT_N), .READ_STROBE_N(READ_STROBE_N),
	.DATA_BUS_OE(DATA_BUS_OE), .BUSY(BUSY), .END_OF_CONVERSION_N(END_OF_CONVERSION_N),
	.TRACK_HOLD(TRACK_HOLD), .ARREADY(ARREADY), .RVALID(RVALID));

/* File: bench/qsas_host_model.sv */
`timescale 1ns/10ps
module qsas_host_model (
	// Clock
	input wire logic clk,
	// Host bus
	output logic start_n,
	output logic cs_n,
	output logic rd_n,
	output logic wr_n,
	output logic [11:0] dbus,
	input wire logic [11:0] dout
);
	initial begin
		start_n = 1'b1;
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		dbus = 12'hA5A;
	end
	task automatic wr_sel(input logic [3:0] val);
		@(posedge clk);
		cs_n <= 1'b0;
		wr_n <= 1'b0;
		dbus <= {8'h00, val};
		@(posedge clk);
		wr_n <= 1'b1;
		@(posedge clk);
		cs_n <= 1'b1;
		dbus <= ~{8'h00, val};
	endtask : wr_sel
	// read after busy, two idle cycles first
	task automatic rd_word(output logic [11:0] val);
		repeat (2) @(posedge clk);
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		repeat (2) @(posedge clk);
		val = dout;
		cs_n <= 1'b1;
		rd_n <= 1'b1;
	endtask : rd_word
	task automatic start_seq;
		repeat (10) @(posedge clk);
		start_n <= 1'b0;
		@(posedge clk);
		start_n <= 1'b1;
		@(posedge clk);
	endtask : start_seq
endmodule : qsas_host_model

/* File: bench/qsas_top_test.sv */
`timescale 1ns/10ps
module qsas_top_test;
	logic clk;
	logic nrst = 1'b0;
	logic start_n;
	logic cs_n;
	logic rd_n;
	logic wr_n;
	logic [11:0] dbus;
	logic [3:0] sel = 4'hD;
	logic src = 1'b0;
	logic cksel = 1'b0;
	logic ext = 1'b0;
	qsas_pkg::qsas_code_t [3:0] code = {12'h001, 12'h7FF, 12'h123, 12'h800};
	logic [11:0] dout;
	logic oe, busy, eoc_n, hold, irq;
	logic [3:0] awaddr = 4'h0;
	logic [3:0] araddr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, q;
	logic [11:0] v;
	int err_count = 0;
	int n_checks = 0;
	int nb, ne;
	qsas_host_model host (.clk(clk), .start_n(start_n), .cs_n(cs_n), .rd_n(rd_n),
		.wr_n(wr_n), .dbus(dbus), .dout(dout));
	qsas_top uut (.CLK(clk), .NRST(nrst), .CONVERSION_START_N(start_n),
		.HW_CHANNEL_SELECT(sel), .SELECT_SOURCE(src), .CLOCK_SOURCE_SELECT(cksel),
		.EXTERNAL_CLOCK_IN(ext), .CHANNEL_CODE(code), .CHIP_SELECT_N(cs_n),
		.READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n), .DATA_BUS_IN(dbus),
		.DATA_BUS_OUT(dout), .DATA_BUS_OE(oe), .BUSY(busy), .END_OF_CONVERSION_N(eoc_n),
		.TRACK_HOLD(hold), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
		.WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
		.BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
		.ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
		.RREADY(rready), .IRQ(irq));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Slow external clock, four system clocks a period
	always begin
		repeat (2) @(posedge clk);
		ext <= ~ext;
	end
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic axi(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		if (w) begin
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
		end else begin
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
		end
		do begin
			@(posedge clk);
			n++;
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (arready === 1'b1) arvalid <= 1'b0;
		end while ((w ? bvalid : rvalid) !== 1'b1 && n < 50);
		q = rdata;
		r = w ? bresp : rresp;
		bready <= 1'b0;
		rready <= 1'b0;
		// One idle edge so the next call never re-raises a ready in this step
		@(posedge clk);
		if (n >= 50) begin
			err_count++;
			close_out();
		end
	endtask : axi
	// Counts busy cycles and end pulses until busy falls
	task automatic run_seq;
		logic pe;
		pe = 1'b1;
		nb = 1;
		ne = 0;
		repeat (400) begin
			@(posedge clk);
			if (eoc_n === 1'b0 && pe === 1'b1) ne++;
			pe = eoc_n;
			if (busy !== 1'b1) break;
			nb++;
		end
		if (busy !== 1'b0) begin
			err_count++;
			close_out();
		end
	endtask : run_seq
	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		axi(1'b0, 4'hC, 32'h0);
		chk(q, 32'h0000000F);
		axi(1'b0, 4'h4, 32'h0);
		chk(q, 32'h00000000);
		axi(1'b0, 4'h2, 32'h0);
		chk(r, 2'h3);
		$display("test registers done");
		host.start_seq();
		sel <= 4'h8;
		fork
			host.start_seq();
			run_seq();
		join
		chk(nb, 131);
		chk(ne, 3);
		host.rd_word(v);
		chk(v, 12'h800);
		host.rd_word(v);
		chk(v, 12'h7FF);
		host.rd_word(v);
		chk(v, 12'h001);
		axi(1'b0, 4'h0, 32'h0);
		chk(q, 32'h00000007);
		chk(irq, 1'b0);
		axi(1'b0, 4'h8, 32'h0);
		chk(q, 32'h00000BDF);
		axi(1'b1, 4'h4, 32'h00000002);
		chk(r, 32'h00000000);
		chk(irq, 1'b1);
		axi(1'b1, 4'h0, 32'h00000007);
		chk(irq, 1'b0);
		$display("test pin sequence done");
		host.wr_sel(4'h2);
		axi(1'b0, 4'hC, 32'h0);
		chk(q, 32'h00000002);
		src <= 1'b1;
		host.start_seq();
		run_seq();
		chk(ne, 1);
		chk(nb, 45);
		host.rd_word(v);
		chk(v, 12'h123);
		$display("test register sequence done");
		cksel <= 1'b1;
		host.start_seq();
		run_seq();
		chk(ne, 1);
		chk(nb >= 60 && nb <= 75, 1'b1);
		$display("test external clock done");
		close_out();
	end
endmodule : qsas_top_test

/* File: include/qsas_defines.svh */
`ifndef QSAS_DEFINES_SVH
`define QSAS_DEFINES_SVH

// Clock and conversion timing
`define QSAS_CLK_MHZ 25.0
`define QSAS_CONV_TIME_US 1.65
`define QSAS_ACQ_TIME_US 0.35
`define QSAS_CONV_CYCLES ($rtoi(`QSAS_CONV_TIME_US * `QSAS_CLK_MHZ))
`define QSAS_ACQ_CYCLES ($rtoi($ceil(`QSAS_ACQ_TIME_US * `QSAS_CLK_MHZ)))
`define QSAS_EXT_CLKS_PER_CONV 6'h10
`define QSAS_EOC_PULSE_CYCLES 2'h2

// Converter geometry
`define QSAS_NUM_CH 4
`define QSAS_CODE_W 12
`define QSAS_CHSEL_RESET 4'hF

// AXI4-Lite register byte offsets
`define QSAS_REG_STATUS 4'h0
`define QSAS_REG_MASK 4'h4
`define QSAS_REG_STATE 4'h8
`define QSAS_REG_CHSEL 4'hC

// Status and mask bit positions
`define QSAS_EVT_CONV_DONE 0
`define QSAS_EVT_SEQ_DONE 1
`define QSAS_EVT_LATE_START 2
`define QSAS_EVT_W 3

// AXI responses
`define QSAS_RESP_OKAY 2'h0
`define QSAS_RESP_DECERR 2'h3

`endif

/* File: include/qsas_pkg.sv */
package qsas_pkg;

	typedef enum logic [1:0] {
		QSAS_IDLE = 2'h0,
		QSAS_CONV = 2'h1,
		QSAS_EOC = 2'h3,
		QSAS_DONE = 2'h2
	} qsas_state_t;

	typedef logic [11:0] qsas_code_t;

	typedef struct packed {
		logic late_start;
		logic seq_done;
		logic conv_done;
	} qsas_evt_t;

	typedef struct packed {
		logic busy;
		logic hold;
		logic acq_ok;
		logic [2:0] count;
		logic [3:0] latched_sel;
		logic [3:0] reg_sel;
	} qsas_state_word_t;

endpackage : qsas_pkg

/* File: verilog/qsas_result_slot.sv */
`timescale 1ns/10ps
`include "qsas_defines.svh"

module qsas_result_slot #(
	parameter int W = `QSAS_CODE_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Load port
	input wire logic load,
	input wire logic [W-1:0] din,
	// Stored value
	output logic [W-1:0] q
);

	logic [W-1:0] q_ff;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			q_ff <= '0;
		end else if (load) begin
			q_ff <= din;
		end
	end

	assign q = q_ff;

endmodule : qsas_result_slot

/* File: verilog/qsas_top.sv */
`timescale 1ns/10ps
`include "qsas_defines.svh"

module qsas_top (
	// Clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// Conversion control pins
	input wire logic CONVERSION_START_N,
	input wire logic [3:0] HW_CHANNEL_SELECT,
	input wire logic SELECT_SOURCE,
	input wire logic CLOCK_SOURCE_SELECT,
	input wire logic EXTERNAL_CLOCK_IN,
	// Sampled channel codes from the analog front end
	input wire qsas_pkg::qsas_code_t [3:0] CHANNEL_CODE,
	// Parallel host bus
	input wire logic CHIP_SELECT_N,
	input wire logic READ_STROBE_N,
	input wire logic WRITE_STROBE_N,
	input wire logic [11:0] DATA_BUS_IN,
	output logic [11:0] DATA_BUS_OUT,
	output logic DATA_BUS_OE,
	// Status pins
	output logic BUSY,
	output logic END_OF_CONVERSION_N,
	output logic TRACK_HOLD,
	// AXI4-Lite write channels
	input wire logic [3:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// AXI4-Lite read channels
	input wire logic [3:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	// Interrupt
	output logic IRQ
);

	localparam logic [5:0] CONV_CYCLES = 6'(`QSAS_CONV_CYCLES);
	localparam logic [3:0] ACQ_CYCLES = 4'(`QSAS_ACQ_CYCLES);

	qsas_pkg::qsas_state_t state_ff;
	qsas_pkg::qsas_state_t nxt_state;
	qsas_pkg::qsas_evt_t evt;
	qsas_pkg::qsas_state_word_t state_word;

	logic start_prev_ff;
	logic wr_prev_ff;
	logic rd_prev_ff;
	logic cs_prev_ff;
	logic ext_prev_ff;
	logic start_edge;
	logic wr_edge;
	logic rd_edge;
	logic ext_edge;
	logic [3:0] chsel_ff;
	logic [3:0] sel_mux;
	logic [3:0] latched_sel_ff;
	logic [3:0] pending_ff;
	logic [1:0] cur_chan;
	logic [5:0] timer_ff;
	logic [1:0] eoc_cnt_ff;
	logic [2:0] count_ff;
	logic [2:0] rd_ptr_ff;
	logic conv_end;
	logic [3:0] slot_load;
	qsas_pkg::qsas_code_t held_ff [4];
	qsas_pkg::qsas_code_t slot_q [4];
	logic [11:0] dout_ff;
	logic busy_ff;
	logic hold_ff;
	logic [3:0] acq_cnt_ff;
	logic [`QSAS_EVT_W-1:0] status_ff;
	logic [`QSAS_EVT_W-1:0] mask_ff;

	// Pins are synchronous; one stage gives edge detection
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			start_prev_ff <= 1'b1;
			wr_prev_ff <= 1'b1;
			rd_prev_ff <= 1'b1;
			cs_prev_ff <= 1'b1;
			ext_prev_ff <= 1'b0;
		end else begin
			start_prev_ff <= CONVERSION_START_N;
			wr_prev_ff <= WRITE_STROBE_N;
			rd_prev_ff <= READ_STROBE_N;
			cs_prev_ff <= CHIP_SELECT_N;
			ext_prev_ff <= EXTERNAL_CLOCK_IN;
		end
	end

	assign start_edge = !start_prev_ff && CONVERSION_START_N;
	assign wr_edge = !wr_prev_ff && WRITE_STROBE_N && !cs_prev_ff;
	assign rd_edge = !rd_prev_ff && READ_STROBE_N && !cs_prev_ff;
	assign ext_edge = !ext_prev_ff && EXTERNAL_CLOCK_IN;

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			chsel_ff <= `QSAS_CHSEL_RESET;
		end else if (wr_edge && READ_STROBE_N) begin
			chsel_ff <= DATA_BUS_IN[3:0];
		end
	end

	assign sel_mux = SELECT_SOURCE ? chsel_ff : HW_CHANNEL_SELECT;

	always_comb begin
		cur_chan = 2'h0;
		for (int i = `QSAS_NUM_CH - 1; i >= 0; i--) begin
			if (pending_ff[i]) begin
				cur_chan = 2'(i);
			end
		end
	end

	assign conv_end = CLOCK_SOURCE_SELECT ? (ext_edge && timer_ff == `QSAS_EXT_CLKS_PER_CONV - 6'h1)
		: (timer_ff == CONV_CYCLES - 6'h1);

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			qsas_pkg::QSAS_IDLE: begin
				if (start_edge) begin
					nxt_state = (sel_mux == 4'h0) ? qsas_pkg::QSAS_DONE : qsas_pkg::QSAS_CONV;
				end
			end
			qsas_pkg::QSAS_CONV: begin
				if (conv_end) begin
					nxt_state = qsas_pkg::QSAS_EOC;
				end
			end
			qsas_pkg::QSAS_EOC: begin
				if (eoc_cnt_ff == `QSAS_EOC_PULSE_CYCLES - 2'h1) begin
					nxt_state = (pending_ff == 4'h0) ? qsas_pkg::QSAS_DONE : qsas_pkg::QSAS_CONV;
				end
			end
			qsas_pkg::QSAS_DONE: begin
				nxt_state = qsas_pkg::QSAS_IDLE;
			end
			default: begin
				nxt_state = qsas_pkg::QSAS_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			state_ff <= qsas_pkg::QSAS_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			latched_sel_ff <= 4'h0;
			pending_ff <= 4'h0;
		end else if (state_ff == qsas_pkg::QSAS_IDLE && start_edge) begin
			latched_sel_ff <= sel_mux;
			pending_ff <= sel_mux;
		end else if (state_ff == qsas_pkg::QSAS_CONV && conv_end) begin
			pending_ff[cur_chan] <= 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			timer_ff <= 6'h0;
		end else if (state_ff != qsas_pkg::QSAS_CONV || conv_end) begin
			timer_ff <= 6'h0;
		end else if (!CLOCK_SOURCE_SELECT || ext_edge) begin
			timer_ff <= timer_ff + 6'h1;
		end
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			eoc_cnt_ff <= 2'h0;
		end else if (state_ff == qsas_pkg::QSAS_EOC) begin
			eoc_cnt_ff <= eoc_cnt_ff + 2'h1;
		end else begin
			eoc_cnt_ff <= 2'h0;
		end
	end

	assign END_OF_CONVERSION_N = (state_ff != qsas_pkg::QSAS_EOC);

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			for (int i = 0; i < `QSAS_NUM_CH; i++) begin
				held_ff[i] <= '0;
			end
		end else if (state_ff == qsas_pkg::QSAS_IDLE && start_edge) begin
			for (int i = 0; i < `QSAS_NUM_CH; i++) begin
				held_ff[i] <= CHANNEL_CODE[i];
			end
		end
	end

	// Results stored in conversion order, so reads walk them in order
	always_comb begin
		slot_load = 4'h0;
		if (state_ff == qsas_pkg::QSAS_CONV && conv_end) begin
			slot_load[count_ff[1:0]] = 1'b1;
		end
	end

	genvar g;
	generate
		for (g = 0; g < `QSAS_NUM_CH; g++) begin : g_slot
			// twos complement code kept as is
			qsas_result_slot #(.W(`QSAS_CODE_W)) u_slot (
				.clk(CLK),
				.nrst(NRST),
				.load(slot_load[g]),
				.din(held_ff[cur_chan]),
				.q(slot_q[g])
			);
		end
	endgenerate

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			count_ff <= 3'h0;
		end else if (state_ff == qsas_pkg::QSAS_IDLE && start_edge) begin
			count_ff <= 3'h0;
		end else if (state_ff == qsas_pkg::QSAS_CONV && conv_end) begin
			count_ff <= count_ff + 3'h1;
		end
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			busy_ff <= 1'b0;
			hold_ff <= 1'b0;
		end else if (state_ff == qsas_pkg::QSAS_IDLE && start_edge) begin
			busy_ff <= 1'b1;
			hold_ff <= 1'b1;
		end else if (state_ff == qsas_pkg::QSAS_DONE) begin
			busy_ff <= 1'b0;
			hold_ff <= 1'b0;
		end
	end

	// Busy rises combinationally with the start edge
	assign BUSY = busy_ff || (state_ff == qsas_pkg::QSAS_IDLE && start_edge);
	assign TRACK_HOLD = hold_ff;

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			acq_cnt_ff <= ACQ_CYCLES;
		end else if (hold_ff) begin
			acq_cnt_ff <= 4'h0;
		end else if (acq_cnt_ff != ACQ_CYCLES) begin
			acq_cnt_ff <= acq_cnt_ff + 4'h1;
		end
	end

	// each read takes the next result, holding at the last one
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			rd_ptr_ff <= 3'h0;
		end else if (state_ff == qsas_pkg::QSAS_IDLE && start_edge) begin
			rd_ptr_ff <= 3'h0;
		end else if (rd_edge && rd_ptr_ff + 3'h1 < count_ff) begin
			rd_ptr_ff <= rd_ptr_ff + 3'h1;
		end
	end

	// data from flip-flop, frozen during a read
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			dout_ff <= 12'h000;
		end else if (CHIP_SELECT_N || READ_STROBE_N) begin
			dout_ff <= slot_q[rd_ptr_ff[1:0]];
		end
	end

	assign DATA_BUS_OUT = dout_ff;
	// drive only under chip select and read
	assign DATA_BUS_OE = !CHIP_SELECT_N && !READ_STROBE_N;

	// Interrupt events
	assign evt.conv_done = (state_ff == qsas_pkg::QSAS_CONV) && conv_end;
	assign evt.seq_done = (state_ff == qsas_pkg::QSAS_DONE);
	assign evt.late_start = start_edge && (state_ff != qsas_pkg::QSAS_IDLE);

	assign state_word.busy = busy_ff;
	assign state_word.hold = hold_ff;
	assign state_word.acq_ok = (acq_cnt_ff == ACQ_CYCLES);
	assign state_word.count = count_ff;
	assign state_word.latched_sel = latched_sel_ff;
	assign state_word.reg_sel = chsel_ff;

	// AXI4-Lite slave
	logic aw_held_ff;
	logic w_held_ff;
	logic [3:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [1:0] rresp_ff;
	logic [31:0] rdata_ff;
	logic do_write;
	logic wr_status;
	logic wr_mask;

	assign AWREADY = !aw_held_ff && !bvalid_ff;
	assign WREADY = !w_held_ff && !bvalid_ff;
	assign ARREADY = !rvalid_ff;
	assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
	assign wr_status = do_write && awaddr_ff == `QSAS_REG_STATUS && wstrb_ff[0];
	assign wr_mask = do_write && awaddr_ff == `QSAS_REG_MASK && wstrb_ff[0];

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			aw_held_ff <= 1'b0;
			awaddr_ff <= 4'h0;
		end else if (AWVALID && AWREADY) begin
			aw_held_ff <= 1'b1;
			awaddr_ff <= AWADDR;
		end else if (do_write) begin
			aw_held_ff <= 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			w_held_ff <= 1'b0;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
		end else if (WVALID && WREADY) begin
			w_held_ff <= 1'b1;
			wdata_ff <= WDATA;
			wstrb_ff <= WSTRB;
		end else if (do_write) begin
			w_held_ff <= 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= `QSAS_RESP_OKAY;
		end else if (do_write) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= (awaddr_ff[1:0] != 2'h0) ? `QSAS_RESP_DECERR : `QSAS_RESP_OKAY;
		end else if (BREADY) begin
			bvalid_ff <= 1'b0;
		end
	end

	// Set wins over a same-cycle clear
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			status_ff <= '0;
		end else begin
			status_ff <= (status_ff & ~(wr_status ? wdata_ff[`QSAS_EVT_W-1:0] : '0)) | evt;
		end
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			mask_ff <= '0;
		end else if (wr_mask) begin
			mask_ff <= wdata_ff[`QSAS_EVT_W-1:0];
		end
	end

	assign IRQ = |(status_ff & mask_ff);

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			rvalid_ff <= 1'b0;
			rresp_ff <= `QSAS_RESP_OKAY;
			rdata_ff <= 32'h0000_0000;
		end else if (ARVALID && ARREADY) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= (ARADDR[1:0] != 2'h0) ? `QSAS_RESP_DECERR : `QSAS_RESP_OKAY;
			case (ARADDR)
				`QSAS_REG_STATUS: rdata_ff <= {29'h0, status_ff};
				`QSAS_REG_MASK: rdata_ff <= {29'h0, mask_ff};
				`QSAS_REG_STATE: rdata_ff <= {18'h0, state_word};
				`QSAS_REG_CHSEL: rdata_ff <= {28'h0, chsel_ff};
				default: rdata_ff <= 32'h0000_0000;
			endcase
		end else if (RREADY) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign BVALID = bvalid_ff;
	assign BRESP = bresp_ff;
	assign RVALID = rvalid_ff;
	assign RRESP = rresp_ff;
	assign RDATA = rdata_ff;

endmodule : qsas_top
